// ==== verification/tdss_analog_model.sv ====
// converter-side model: shared temperature converter feeding the select block
`timescale 1ns/10ps
module tdss_analog_model (
	input wire logic i_clk,
	input wire logic i_adc_enable,
	output logic o_adc_valid,
	output logic [5:0] o_adc_result
);
	initial begin
		o_adc_valid = 1'b0;
		o_adc_result = 6'h2A;
	end

	// ----------------------------------------------------------------
	// conversion pulses, gap cycles apart; result line toggles between
	// ----------------------------------------------------------------
	task automatic convert(input logic [5:0] v, input int n, input int gap);
		for (int k = 0; k < n; k++) begin
			repeat (gap) @(posedge i_clk);
			if (i_adc_enable === 1'b1) begin
				o_adc_valid <= 1'b1;
				o_adc_result <= v;
				@(posedge i_clk);
				o_adc_valid <= 1'b0;
				o_adc_result <= ~v;
			end
		end
	endtask : convert
endmodule : tdss_analog_model

// ==== verification/testbench.sv ====
// self-checking bench for the converter source select block
`timescale 1ns/10ps
module testbench;
	logic i_clk;
	logic i_reset_n;
	logic [8:0] i_addr;
	logic [7:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [7:0] o_rdata;
	logic i_supply_por;
	logic i_supply_adc_ok;
	logic i_adc_valid;
	logic [5:0] i_adc_result;
	logic o_analog_power_up;
	logic o_adc_enable;
	logic [7:0] o_conv1_byte;
	logic [7:0] o_conv2_byte;
	tdss_pkg::tdss_chan_cfg_t o_out1_cfg;
	tdss_pkg::tdss_chan_cfg_t o_out2_cfg;
	int failures = 0;
	int tests_run = 0;

	tdss_dac_select tdss_dac_select_inst (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.i_supply_por(i_supply_por),
		.i_supply_adc_ok(i_supply_adc_ok),
		.i_adc_valid(i_adc_valid),
		.i_adc_result(i_adc_result),
		.o_analog_power_up(o_analog_power_up),
		.o_adc_enable(o_adc_enable),
		.o_conv1_byte(o_conv1_byte),
		.o_conv2_byte(o_conv2_byte),
		.o_out1_cfg(o_out1_cfg),
		.o_out2_cfg(o_out2_cfg)
	);

	tdss_analog_model tdss_analog_model_inst (
		.i_clk(i_clk),
		.i_adc_enable(o_adc_enable),
		.o_adc_valid(i_adc_valid),
		.o_adc_result(i_adc_result)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] t1(input logic [5:0] r);
		return {2'h1, r};
	endfunction : t1

	function automatic logic [7:0] t2(input logic [5:0] r);
		return {2'h2, ~r};
	endfunction : t2

	task automatic test_done();
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string n);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(n, o_rdata, exp);
	endtask : rd

	// which 0: analog power-up, 1: converter enable
	task automatic wait_hi(input int which);
		int k;
		for (k = 0; k < 50; k++) begin
			@(posedge i_clk);
			#1;
			if ((which == 0 ? o_analog_power_up : o_adc_enable) === 1'b1)
				break;
		end
		if (k == 50) begin
			failures++;
			test_done();
		end
	endtask : wait_hi

	task automatic conv(input logic [7:0] e1, input logic [7:0] e2);
		repeat (4) @(posedge i_clk);
		#1;
		chk("conv1", o_conv1_byte, e1);
		chk("conv2", o_conv2_byte, e2);
	endtask : conv

	// ----------------------------------------------------------------
	// clock, watchdog
	// ----------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		test_done();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		i_reset_n = 1'b0;
		i_addr = 9'h000;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_supply_por = 1'b0;
		i_supply_adc_ok = 1'b0;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		conv(8'h00, 8'h00);
		for (int r = 0; r < 64; r++) begin
			wr(tdss_pkg::TBL1_BASE + 9'(r), t1(6'(r)));
			wr(tdss_pkg::TBL2_BASE + 9'(r), t2(6'(r)));
		end
		wr(tdss_pkg::ADDR_CTRL0, 8'h00);
		wr(tdss_pkg::ADDR_CTRL5, 8'h00);
		rd(9'h086, 8'h00, "unmapped86");
		rd(9'h110, 8'h00, "unmapped110");
		rd(tdss_pkg::TBL1_BASE + 9'h005, t1(6'h05), "tbl1row5");
		rd(tdss_pkg::TBL2_BASE + 9'h03F, t2(6'h3F), "tbl2row63");
		// power-up with filter on
		@(posedge i_clk);
		i_supply_por <= 1'b1;
		wait_hi(0);
		repeat (5) @(posedge i_clk);
		#1;
		chk("adc_en_early", {7'h00, o_adc_enable}, 8'h00);
		chk("conv1_pre", o_conv1_byte, 8'h00);
		@(posedge i_clk);
		i_supply_adc_ok <= 1'b1;
		wait_hi(1);
		tdss_analog_model_inst.convert(6'h05, 3, 2);
		tdss_analog_model_inst.convert(6'h06, 1, 2);
		tdss_analog_model_inst.convert(6'h05, 3, 3);
		conv(8'h00, 8'h00);
		tdss_analog_model_inst.convert(6'h05, 1, 2);
		conv(t1(6'h05), t2(6'h05));
		rd(tdss_pkg::ADDR_STATUS, 8'h05, "status");
		// filtered refresh in run
		tdss_analog_model_inst.convert(6'h09, 3, 1);
		conv(t1(6'h05), t2(6'h05));
		tdss_analog_model_inst.convert(6'h09, 1, 1);
		conv(t1(6'h09), t2(6'h09));
		// register row select
		wr(tdss_pkg::ADDR_ROW1, 8'hE3);
		rd(tdss_pkg::ADDR_ROW1, 8'h23, "row1");
		wr(tdss_pkg::ADDR_CTRL5, 8'h10);
		conv(t1(6'h23), t2(6'h09));
		wr(tdss_pkg::ADDR_ROW2, 8'h0A);
		wr(tdss_pkg::ADDR_CTRL5, 8'h50);
		tdss_analog_model_inst.convert(6'h11, 4, 1);
		conv(t1(6'h23), t2(6'h0A));
		// direct values
		wr(tdss_pkg::ADDR_VAL2, 8'h5A);
		conv(t1(6'h23), t2(6'h0A));
		wr(tdss_pkg::ADDR_VAL1, 8'hA5);
		wr(tdss_pkg::ADDR_CTRL5, 8'hF0);
		conv(8'hA5, 8'h5A);
		wr(tdss_pkg::ADDR_VAL1, 8'h3C);
		#1;
		chk("conv1_hold", o_conv1_byte, 8'hA5);
		@(posedge i_clk);
		#1;
		chk("conv1_next", o_conv1_byte, 8'h3C);
		// direction and full-scale
		wr(tdss_pkg::ADDR_CTRL0, 8'h01);
		wr(tdss_pkg::ADDR_CTRL5, 8'h06);
		conv(8'(t1(6'h11)), t2(6'h11));
		chk("out1_cfg", {5'h00, o_out1_cfg}, 8'h06);
		chk("out2_cfg", {5'h00, o_out2_cfg}, 8'h01);
		wr(tdss_pkg::ADDR_CTRL0, 8'h02);
		conv(t1(6'h11), t2(6'h11));
		chk("out1_cfg2", {5'h00, o_out1_cfg}, 8'h02);
		chk("out2_cfg2", {5'h00, o_out2_cfg}, 8'h05);
		// restart with filter off and direct select recalled
		wr(tdss_pkg::ADDR_CTRL0, 8'h04);
		wr(tdss_pkg::ADDR_CTRL5, 8'h20);
		i_supply_por <= 1'b0;
		conv(8'h00, 8'h00);
		chk("power_off", {7'h00, o_analog_power_up}, 8'h00);
		// reset clears the live copies so the recall below is visible
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(tdss_pkg::ADDR_CTRL5, 8'h00, "ctrl5_rst");
		chk("out1_cfg_rst", {5'h00, o_out1_cfg}, 8'h00);
		chk("conv1_rst", o_conv1_byte, 8'h00);
		@(posedge i_clk);
		i_supply_por <= 1'b1;
		wait_hi(0);
		rd(tdss_pkg::ADDR_CTRL5, 8'h20, "recall5");
		rd(tdss_pkg::ADDR_CTRL0, 8'h04, "recall0");
		wr(tdss_pkg::ADDR_VAL1, 8'h77);
		wait_hi(1);
		conv(8'h00, 8'h00);
		tdss_analog_model_inst.convert(6'h0C, 1, 2);
		conv(8'h77, t2(6'h0C));
		wr(tdss_pkg::ADDR_STATUS, 8'hFF);
		rd(tdss_pkg::ADDR_STATUS, 8'h0C, "status_ro");
		test_done();
	end
endmodule : testbench

// ==== verilog/tdss_dac_select.sv ====
// converter source select, filter and power-up sequence
//
// Function
// - table row address is table base plus row selection value
// - two 64-row tables; selected row byte feeds its converter
// - by default the shared converter result selects rows of both tables
// - bypass takes row bits from low six bits of row registers
// - both selects zero: converter one from table one by result
// - table select set: converter one from table one by register row
// - direct select set: converter one from its value register
// - same three-way choice for converter two with its own bits
// - one shared result, all channel settings independent
// - per-channel direction bit held in first control register
// - per-channel two-bit full-scale field drives resistor choice
// - recall control bits first, then power analog circuits
// - enable conversions only after second supply threshold
// - filtered: first result used after four identical conversions
// - both converter bytes zero until first table bytes applied
// - filter off: one conversion suffices at power-up
// - recalled select bits govern the first converter access
// - stored result refreshed per filter setting
// - direct mode uses value registers; otherwise they are ignored
`timescale 1ns/10ps
module tdss_dac_select (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [8:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_supply_por,
	input wire logic i_supply_adc_ok,
	input wire logic i_adc_valid,
	input wire logic [5:0] i_adc_result,
	output logic o_analog_power_up,
	output logic o_adc_enable,
	output logic [7:0] o_conv1_byte,
	output logic [7:0] o_conv2_byte,
	output tdss_pkg::tdss_chan_cfg_t o_out1_cfg,
	output tdss_pkg::tdss_chan_cfg_t o_out2_cfg
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [8:0] row_addr(input logic [8:0] base, input logic [5:0] row);
		row_addr = base + {3'h0, row};
	endfunction : row_addr

	function automatic logic is_table(input logic [8:0] a);
		is_table = (a >= tdss_pkg::TBL1_BASE) && (a <= tdss_pkg::TBL_END);
	endfunction : is_table

	function automatic logic [7:0] mem_index(input logic [8:0] a);
		logic [8:0] diff;
		diff = a - tdss_pkg::TBL1_BASE;
		if (a == tdss_pkg::ADDR_CTRL0) begin
			mem_index = tdss_pkg::NV_CTRL0_IDX;
		end else if (a == tdss_pkg::ADDR_CTRL5) begin
			mem_index = tdss_pkg::NV_CTRL5_IDX;
		end else begin
			mem_index = diff[7:0];
		end
	endfunction : mem_index

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tdss_pkg::tdss_seq_t state_reg;
	tdss_pkg::tdss_seq_t state_next;
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl5_reg;
	logic [5:0] row1_reg;
	logic [5:0] row2_reg;
	logic [7:0] val1_reg;
	logic [7:0] val2_reg;
	logic [5:0] adc_value_reg;
	logic adc_ready_reg;
	logic [5:0] last_reg;
	logic have_last_reg;
	logic [1:0] run_cnt_reg;
	logic [7:0] rdata_reg;
	logic tbl_rd_reg;
	logic [7:0] mem_a_q;
	logic [7:0] tbl1_q;
	logic [7:0] tbl2_q;
	logic adc_on;
	logic filt_off;
	logic match;
	logic upd;
	tdss_pkg::tdss_chan_sel_t ch1;
	tdss_pkg::tdss_chan_sel_t ch2;
	logic [8:0] tbl1_addr;
	logic [8:0] tbl2_addr;
	logic [7:0] port_a_idx;
	logic mem_we;

	// ----------------------------------------------------------------
	// channel selection
	// ----------------------------------------------------------------
	assign ch1 = '{table_direct: ctrl5_reg[tdss_pkg::C5_TBL1_SEL],
		conv_direct: ctrl5_reg[tdss_pkg::C5_CONV1_SEL],
		row: row1_reg, value: val1_reg};
	assign ch2 = '{table_direct: ctrl5_reg[tdss_pkg::C5_TBL2_SEL],
		conv_direct: ctrl5_reg[tdss_pkg::C5_CONV2_SEL],
		row: row2_reg, value: val2_reg};
	// result by default, register row in bypass
	assign tbl1_addr = row_addr(tdss_pkg::TBL1_BASE,
		ch1.table_direct ? ch1.row : adc_value_reg);
	assign tbl2_addr = row_addr(tdss_pkg::TBL2_BASE,
		ch2.table_direct ? ch2.row : adc_value_reg);
	assign filt_off = ctrl0_reg[tdss_pkg::C0_FILT_OFF];
	assign adc_on = (state_reg == tdss_pkg::ST_CONVERT) || (state_reg == tdss_pkg::ST_RUN);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always_comb begin
		case (state_reg)
			tdss_pkg::ST_RECALL_A: port_a_idx = tdss_pkg::NV_CTRL0_IDX;
			tdss_pkg::ST_RECALL_B: port_a_idx = tdss_pkg::NV_CTRL5_IDX;
			default: port_a_idx = mem_index(i_addr);
		endcase
	end

	assign mem_we = i_wr && (is_table(i_addr) || i_addr == tdss_pkg::ADDR_CTRL0
		|| i_addr == tdss_pkg::ADDR_CTRL5);

	tdss_nvm #(
		.DEPTH(tdss_pkg::MEM_DEPTH),
		.AW(tdss_pkg::MEM_AW),
		.DW(tdss_pkg::DATA_W)
	) u_nvm (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_we(mem_we),
		.i_waddr(mem_index(i_addr)),
		.i_wdata(i_wdata),
		.i_raddr_a(port_a_idx),
		.i_raddr_b(mem_index(tbl1_addr)),
		.i_raddr_c(mem_index(tbl2_addr)),
		.o_rdata_a(mem_a_q),
		.o_rdata_b(tbl1_q),
		.o_rdata_c(tbl2_q)
	);

	// ----------------------------------------------------------------
	// power-up sequence
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			tdss_pkg::ST_WAIT_POR: if (i_supply_por) state_next = tdss_pkg::ST_RECALL_A;
			tdss_pkg::ST_RECALL_A: state_next = tdss_pkg::ST_RECALL_B;
			tdss_pkg::ST_RECALL_B: state_next = tdss_pkg::ST_RECALL_C;
			tdss_pkg::ST_RECALL_C: state_next = tdss_pkg::ST_ANALOG;
			tdss_pkg::ST_ANALOG: if (i_supply_adc_ok) state_next = tdss_pkg::ST_CONVERT;
			tdss_pkg::ST_CONVERT: if (adc_ready_reg) state_next = tdss_pkg::ST_RUN;
			tdss_pkg::ST_RUN: state_next = tdss_pkg::ST_RUN;
			default: state_next = tdss_pkg::ST_WAIT_POR;
		endcase
		// supply dip restarts the sequence
		if (!i_supply_por) begin
			state_next = tdss_pkg::ST_WAIT_POR;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= tdss_pkg::ST_WAIT_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_analog_power_up = (state_reg == tdss_pkg::ST_ANALOG) || adc_on;
	assign o_adc_enable = adc_on;

	// ----------------------------------------------------------------
	// conversion filter
	// ----------------------------------------------------------------
	assign match = have_last_reg && (i_adc_result == last_reg);
	assign upd = i_adc_valid && adc_on
		&& (filt_off || (match && run_cnt_reg >= tdss_pkg::FILTER_HITS));

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			last_reg <= 6'h00;
			have_last_reg <= 1'b0;
			run_cnt_reg <= 2'h0;
		end else if (!adc_on) begin
			have_last_reg <= 1'b0;
			run_cnt_reg <= 2'h0;
		end else if (i_adc_valid) begin
			last_reg <= i_adc_result;
			have_last_reg <= 1'b1;
			if (!match) begin
				run_cnt_reg <= 2'h0;
			end else if (run_cnt_reg != 2'h3) begin
				run_cnt_reg <= run_cnt_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			adc_value_reg <= 6'h00;
			adc_ready_reg <= 1'b0;
		end else begin
			if (upd) begin
				adc_value_reg <= i_adc_result;
			end
			adc_ready_reg <= adc_on && (adc_ready_reg || upd);
		end
	end

	// ----------------------------------------------------------------
	// converter inputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_conv1_byte <= tdss_pkg::CONV_IDLE;
			o_conv2_byte <= tdss_pkg::CONV_IDLE;
		end else if (state_reg != tdss_pkg::ST_RUN) begin
			o_conv1_byte <= tdss_pkg::CONV_IDLE;
			o_conv2_byte <= tdss_pkg::CONV_IDLE;
		end else begin
			// recalled selects already in force at first access
			o_conv1_byte <= ch1.conv_direct ? ch1.value : tbl1_q;
			o_conv2_byte <= ch2.conv_direct ? ch2.value : tbl2_q;
		end
	end

	assign o_out1_cfg = '{direction: ctrl0_reg[tdss_pkg::C0_DIR1],
		fullscale: ctrl5_reg[tdss_pkg::C5_FS1_LO +: 2]};
	assign o_out2_cfg = '{direction: ctrl0_reg[tdss_pkg::C0_DIR2],
		fullscale: ctrl5_reg[tdss_pkg::C5_FS2_LO +: 2]};

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl0_reg <= tdss_pkg::CTRL0_RST;
			ctrl5_reg <= tdss_pkg::CTRL5_RST;
		end else if (state_reg == tdss_pkg::ST_RECALL_B) begin
			ctrl0_reg <= mem_a_q;
		end else if (state_reg == tdss_pkg::ST_RECALL_C) begin
			ctrl5_reg <= mem_a_q;
		end else if (i_wr && i_addr == tdss_pkg::ADDR_CTRL0) begin
			ctrl0_reg <= i_wdata;
		end else if (i_wr && i_addr == tdss_pkg::ADDR_CTRL5) begin
			ctrl5_reg <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			row1_reg <= tdss_pkg::ROW_RST;
			row2_reg <= tdss_pkg::ROW_RST;
			val1_reg <= tdss_pkg::VAL_RST;
			val2_reg <= tdss_pkg::VAL_RST;
		end else if (i_wr) begin
			case (i_addr)
				tdss_pkg::ADDR_ROW1: row1_reg <= i_wdata[5:0];
				tdss_pkg::ADDR_ROW2: row2_reg <= i_wdata[5:0];
				tdss_pkg::ADDR_VAL1: val1_reg <= i_wdata;
				tdss_pkg::ADDR_VAL2: val2_reg <= i_wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_reg <= 8'h00;
			tbl_rd_reg <= 1'b0;
		end else begin
			tbl_rd_reg <= i_rd && is_table(i_addr);
			if (i_rd) begin
				case (i_addr)
					tdss_pkg::ADDR_CTRL0: rdata_reg <= ctrl0_reg;
					tdss_pkg::ADDR_ROW1: rdata_reg <= {2'h0, row1_reg};
					tdss_pkg::ADDR_ROW2: rdata_reg <= {2'h0, row2_reg};
					tdss_pkg::ADDR_VAL1: rdata_reg <= val1_reg;
					tdss_pkg::ADDR_VAL2: rdata_reg <= val2_reg;
					tdss_pkg::ADDR_CTRL5: rdata_reg <= ctrl5_reg;
					tdss_pkg::ADDR_STATUS: rdata_reg <= {2'h0, adc_value_reg};
					default: rdata_reg <= 8'h00;
				endcase
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end

	assign o_rdata = tbl_rd_reg ? mem_a_q : rdata_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_filter_hit;
		i_adc_valid && adc_on && !filt_off && match && (run_cnt_reg >= 2'h2);
	endsequence

	sequence s_recall_walk;
		(state_reg == tdss_pkg::ST_RECALL_B && i_supply_por)
			##1 (state_reg == tdss_pkg::ST_RECALL_C && i_supply_por);
	endsequence

	a_zero_until_run: assert property (
		(state_reg != tdss_pkg::ST_RUN) |=> (o_conv1_byte == 8'h00 && o_conv2_byte == 8'h00))
		else $error("converter byte not zero before first apply");

	a_recall_order: assert property (
		(state_reg == tdss_pkg::ST_RECALL_A && i_supply_por)
			|=> (state_reg == tdss_pkg::ST_RECALL_B))
		else $error("recall steps out of order");

	a_recall_walk: assert property (
		(state_reg == tdss_pkg::ST_RECALL_A && i_supply_por) ##1 s_recall_walk
			|=> (state_reg == tdss_pkg::ST_ANALOG))
		else $error("recall walk broken");

	a_power_after_recall: assert property (
		$rose(o_analog_power_up) |-> $past(state_reg) == tdss_pkg::ST_RECALL_C)
		else $error("analog power before recall finished");

	a_adc_gate: assert property (
		$rose(o_adc_enable) |-> $past(i_supply_adc_ok) && $past(o_analog_power_up))
		else $error("converter enabled before threshold");

	a_filter_hit: assert property (
		s_filter_hit |=> adc_value_reg == $past(i_adc_result) && adc_ready_reg)
		else $error("filtered result not stored after four matches");

	a_filter_miss: assert property (
		(i_adc_valid && !filt_off && !match) |=> $stable(adc_value_reg))
		else $error("result stored without four matches");

	a_nofilter_take: assert property (
		(i_adc_valid && adc_on && filt_off) |=> adc_value_reg == $past(i_adc_result))
		else $error("unfiltered result not stored");

	a_direct_path1: assert property (
		(state_reg == tdss_pkg::ST_RUN && ch1.conv_direct) |=> o_conv1_byte == $past(val1_reg))
		else $error("converter one not fed from value register");

	a_table_path2: assert property (
		(state_reg == tdss_pkg::ST_RUN && !ch2.conv_direct) |=> o_conv2_byte == $past(tbl2_q))
		else $error("converter two not fed from table two");

	a_row_source1: assert property (
		(!ch1.table_direct ##1 ch1.table_direct && $stable(row1_reg))
			|-> tbl1_addr - tdss_pkg::TBL1_BASE == {3'h0, row1_reg})
		else $error("table one row not taken from register");
endmodule : tdss_dac_select

// ==== verilog/tdss_nvm.sv ====
// byte storage for both tables and recalled control bytes
`timescale 1ns/10ps
module tdss_nvm #(
	parameter int DEPTH = 130,
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr_a,
	input wire logic [AW-1:0] i_raddr_b,
	input wire logic [AW-1:0] i_raddr_c,
	output logic [DW-1:0] o_rdata_a,
	output logic [DW-1:0] o_rdata_b,
	output logic [DW-1:0] o_rdata_c
);
	generate
		if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad
			$error("tdss_nvm: depth does not fit address width");
		end
	endgenerate

	// array holds no reset so contents outlive a reset
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we && (int'(i_waddr) < DEPTH)) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata_a <= '0;
			o_rdata_b <= '0;
			o_rdata_c <= '0;
		end else begin
			o_rdata_a <= (int'(i_raddr_a) < DEPTH) ? mem[i_raddr_a] : '0;
			o_rdata_b <= (int'(i_raddr_b) < DEPTH) ? mem[i_raddr_b] : '0;
			o_rdata_c <= (int'(i_raddr_c) < DEPTH) ? mem[i_raddr_c] : '0;
		end
	end
endmodule : tdss_nvm

// ==== verilog/tdss_pkg.sv ====
// shared constants and types for the table-driven converter source select
package tdss_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int ROW_W = 6;
	localparam int MEM_AW = 8;
	localparam int MEM_DEPTH = 130;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [8:0] ADDR_CTRL0 = 9'h080;
	localparam logic [8:0] ADDR_ROW1 = 9'h081;
	localparam logic [8:0] ADDR_ROW2 = 9'h082;
	localparam logic [8:0] ADDR_VAL1 = 9'h083;
	localparam logic [8:0] ADDR_VAL2 = 9'h084;
	localparam logic [8:0] ADDR_CTRL5 = 9'h085;
	localparam logic [8:0] ADDR_STATUS = 9'h087;
	localparam logic [8:0] TBL1_BASE = 9'h090;
	localparam logic [8:0] TBL2_BASE = 9'h0D0;
	localparam logic [8:0] TBL_END = 9'h10F;

	// ----------------------------------------------------------------
	// storage slots for the recalled control bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] NV_CTRL0_IDX = 8'h80;
	localparam logic [7:0] NV_CTRL5_IDX = 8'h81;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int C0_DIR1 = 0;
	localparam int C0_DIR2 = 1;
	localparam int C0_FILT_OFF = 2;
	localparam int C5_FS1_LO = 0;
	localparam int C5_FS2_LO = 2;
	localparam int C5_TBL1_SEL = 4;
	localparam int C5_CONV1_SEL = 5;
	localparam int C5_TBL2_SEL = 6;
	localparam int C5_CONV2_SEL = 7;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL0_RST = 8'h00;
	localparam logic [7:0] CTRL5_RST = 8'h00;
	localparam logic [5:0] ROW_RST = 6'h00;
	localparam logic [7:0] VAL_RST = 8'h00;
	localparam logic [7:0] CONV_IDLE = 8'h00;
	localparam logic [1:0] FILTER_HITS = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_WAIT_POR = 3'b000,
		ST_RECALL_A = 3'b001,
		ST_RECALL_B = 3'b010,
		ST_RECALL_C = 3'b011,
		ST_ANALOG = 3'b100,
		ST_CONVERT = 3'b101,
		ST_RUN = 3'b110
	} tdss_seq_t;

	typedef struct packed {
		logic table_direct;
		logic conv_direct;
		logic [5:0] row;
		logic [7:0] value;
	} tdss_chan_sel_t;

	typedef struct packed {
		logic direction;
		logic [1:0] fullscale;
	} tdss_chan_cfg_t;
endpackage : tdss_pkg
